// ===== cfts_regs.svh
// constants for the can frame timestamp timer: offsets, fields, resets, timing
// assumes inclusion by the timer and bench files only
//
// Contract
// - a 16-bit counter, read as high and low byte, is the common time base.
// - the counter stays stopped until the controller enable bit is set.
// - in time-triggered mode the count is copied to the sync capture at start or end of frame per edge select.
// - in time-triggered mode each frame is sent once, with no retransmission after an error.
// - every message object can be stamped with the count on its own reception or transmission.
// - a received frame is stamped in the cycle its receive-complete flag is set.
// - a sent frame is stamped in the cycle its transmit-complete flag is set.
// - the counter wraps from all ones to zero and keeps counting.
// - each wrap pulses timer_irq only when the overflow interrupt enable is set, and always sets the wrap status bit that irq_mask gates onto irq.
// - the general control register is 8 bits at ABh, bits abort, overload, tt mode, edge select, listen, test, on, reset.
// - setting controller on enables the controller and clock; clearing it stops after the frame in progress ends.
`ifndef CFTS_REGS_SVH
`define CFTS_REGS_SVH

// register indices (printed offset is not a multiple of four: byte address = 4 * index)
`define CFTS_IDX_GCON      8'hAB
`define CFTS_IDX_TIMH      8'hB0
`define CFTS_IDX_TIML      8'hB1
`define CFTS_IDX_TTCH      8'hB2
`define CFTS_IDX_TTCL      8'hB3
`define CFTS_IDX_STMPH     8'hB4
`define CFTS_IDX_STMPL     8'hB5
`define CFTS_IDX_OBJSEL    8'hB6
`define CFTS_IDX_IRQSTAT   8'hB7
`define CFTS_IDX_IRQMASK   8'hB8
`define CFTS_IDX_PRESC     8'hB9

// general control fields
`define CFTS_GCON_ABORT_BIT 7
`define CFTS_GCON_OVLD_BIT  6
`define CFTS_GCON_TTM_BIT   5
`define CFTS_GCON_EDGE_BIT  4
`define CFTS_GCON_LSTN_BIT  3
`define CFTS_GCON_TEST_BIT  2
`define CFTS_GCON_ON_BIT    1
`define CFTS_GCON_CLR_BIT   0
`define CFTS_GCON_RESET     8'h00

// interrupt status / mask fields
`define CFTS_IRQ_WRAP_BIT   0
`define CFTS_IRQ_SYNC_BIT   1
`define CFTS_IRQ_STAMP_BIT  2
`define CFTS_IRQ_RESET      8'h00

// prescaler reset: tick every (value+1) clocks
`define CFTS_PRESC_RESET    8'h00

// the controller needs two clocks before the counter starts
`define CFTS_START_CYCLES   2

`endif

// ===== cfts_pkg.sv
// types for the can frame timestamp timer
// assumes cfts_regs.svh sits in the same folder
package cfts_pkg;
   typedef enum logic [1:0] {CFTS_OFF, CFTS_STARTING, CFTS_RUN, CFTS_DRAIN} cfts_run_t;
   typedef logic [15:0] cfts_count_t;
endpackage

// ===== cfts_stamp_mem.sv
// per-object stamp store: one 16-bit entry for every message object
// assumes the write strobe carries a single-cycle sample of the counter
`timescale 1ns/1ps
module cfts_stamp_mem #(
   parameter int NUM_OBJ = 15,
   parameter int OBJ_W   = 4
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 wr_en,
   input  wire logic [OBJ_W-1:0]     wr_obj,
   input  wire cfts_pkg::cfts_count_t wr_data,
   input  wire logic [OBJ_W-1:0]     rd_obj,
   output cfts_pkg::cfts_count_t     rd_data
);
   import cfts_pkg::*;

   cfts_count_t mem [NUM_OBJ];
   cfts_count_t next_mem [NUM_OBJ];

   // write the stamp into the addressed object only
   always_comb begin
      for (int i = 0; i < NUM_OBJ; i++) begin
         next_mem[i] = mem[i];
      end
      if (wr_en && (int'(wr_obj) < NUM_OBJ)) begin
         next_mem[wr_obj] = wr_data;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < NUM_OBJ; i++) begin
            mem[i] <= 16'h0000;
         end
      end else begin
         for (int i = 0; i < NUM_OBJ; i++) begin
            mem[i] <= next_mem[i];
         end
      end
   end

   // unimplemented object numbers read as zero
   always_comb begin
      rd_data = (int'(rd_obj) < NUM_OBJ) ? mem[rd_obj] : 16'h0000;
   end
endmodule // cfts_stamp_mem

// ===== cfts_timer.sv
// can frame timestamp timer: time base, sync capture, object stamps, apb registers
// assumes the protocol engine gives one-cycle event pulses synchronous to pclk
`timescale 1ns/1ps
`include "cfts_regs.svh"
module cfts_timer #(
   parameter int NUM_OBJ = 15,
   parameter int OBJ_W   = 4
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [11:0]          paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 frame_start,
   input  wire logic                 frame_end,
   input  wire logic                 frame_busy,
   input  wire logic                 rx_complete,
   input  wire logic                 tx_complete,
   input  wire logic [OBJ_W-1:0]     done_obj,
   input  wire logic                 timer_overflow_irq_enable,
   output logic                      timer_irq,
   output logic                      irq,
   output logic                      controller_enable,
   output logic                      single_shot,
   output logic [7:0]                can_general_control_q
);
   import cfts_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // state
   cfts_run_t   run, next_run;
   logic [1:0]  start_cnt, next_start_cnt;
   logic [7:0]  presc, next_presc, pcnt, next_pcnt;
   cfts_count_t count, next_count;
   cfts_count_t sync_cap, next_sync_cap;
   logic [7:0]  gcon, next_gcon;
   logic [7:0]  irq_stat, next_irq_stat, irq_mask, next_irq_mask;
   logic [OBJ_W-1:0] obj_sel, next_obj_sel;
   logic [31:0] next_prdata;
   logic        next_irq, next_timer_irq;
   logic        running, tick, wrap, sync_evt, stamp_evt;
   logic        wr_acc, rd_acc, rd_setup;
   logic [9:0]  idx;
   cfts_count_t stamp_rd;

   // byte address to register index
   function automatic logic [9:0] reg_index(input logic [11:0] a);
      return a[11:2];
   endfunction

   assign idx     = reg_index(paddr);
   assign wr_acc  = psel && penable && pwrite;
   assign rd_acc  = psel && penable && !pwrite;
   // read data is fetched at the setup edge so that it stands together with pready
   assign rd_setup = psel && !penable && !pwrite;
   assign running = (run == CFTS_RUN) || (run == CFTS_DRAIN);
   assign tick    = running && (pcnt == presc);
   assign wrap    = tick && (count == 16'hFFFF);
   assign sync_evt  = running && gcon[`CFTS_GCON_TTM_BIT] &&
                      (gcon[`CFTS_GCON_EDGE_BIT] ? frame_end : frame_start);
   assign stamp_evt = running && (rx_complete || tx_complete);

   ////////////////////////////////////////////////////////////////////////////
   // enable sequencing: two clocks to start, drain the live frame on disable
   always_comb begin
      next_run       = run;
      next_start_cnt = start_cnt;
      unique case (run)
         CFTS_OFF: begin
            if (gcon[`CFTS_GCON_ON_BIT]) begin
               next_run       = CFTS_STARTING;
               next_start_cnt = 2'(`CFTS_START_CYCLES - 1);
            end
         end
         CFTS_STARTING: begin
            if (!gcon[`CFTS_GCON_ON_BIT]) begin
               next_run = CFTS_OFF;
            end else if (start_cnt == 2'h0) begin
               next_run = CFTS_RUN;
            end else begin
               next_start_cnt = start_cnt - 2'h1;
            end
         end
         CFTS_RUN: begin
            if (!gcon[`CFTS_GCON_ON_BIT]) begin
               next_run = frame_busy ? CFTS_DRAIN : CFTS_OFF;
            end
         end
         CFTS_DRAIN: begin
            if (gcon[`CFTS_GCON_ON_BIT]) begin
               next_run = CFTS_RUN;
            end else if (!frame_busy) begin
               next_run = CFTS_OFF;
            end
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run       <= CFTS_OFF;
         start_cnt <= 2'h0;
      end else begin
         run       <= next_run;
         start_cnt <= next_start_cnt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // prescaler and time base; general reset clears the count
   always_comb begin
      next_pcnt  = running ? (tick ? 8'h00 : pcnt + 8'h01) : 8'h00;
      next_count = count;
      if (gcon[`CFTS_GCON_CLR_BIT]) begin
         next_count = 16'h0000;
      end else if (tick) begin
         next_count = count + 16'h0001;
      end
      // whole count latched at once, so both bytes match
      next_sync_cap = sync_evt ? count : sync_cap;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pcnt     <= 8'h00;
         count    <= 16'h0000;
         sync_cap <= 16'h0000;
      end else begin
         pcnt     <= next_pcnt;
         count    <= next_count;
         sync_cap <= next_sync_cap;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // per-object stamps
   cfts_stamp_mem #(
      .NUM_OBJ (NUM_OBJ),
      .OBJ_W   (OBJ_W)
   ) u_stamp (
      .pclk    (pclk),
      .presetn (presetn),
      .wr_en   (stamp_evt),
      .wr_obj  (done_obj),
      .wr_data (count),
      .rd_obj  (obj_sel),
      .rd_data (stamp_rd)
   );

   ////////////////////////////////////////////////////////////////////////////
   // apb registers; zero wait states; status clears on read, set wins
   always_comb begin
      next_gcon     = gcon;
      next_presc    = presc;
      next_irq_mask = irq_mask;
      next_obj_sel  = obj_sel;
      next_prdata   = 32'h0000_0000;
      next_irq_stat = irq_stat;
      if (wr_acc) begin
         unique case (idx)
            10'(`CFTS_IDX_GCON):    next_gcon     = pwdata[7:0];
            10'(`CFTS_IDX_PRESC):   next_presc    = pwdata[7:0];
            10'(`CFTS_IDX_IRQMASK): next_irq_mask = pwdata[7:0];
            10'(`CFTS_IDX_OBJSEL):  next_obj_sel  = pwdata[OBJ_W-1:0];
            default: ;
         endcase
      end
      // general reset acts once and self-clears
      if (gcon[`CFTS_GCON_CLR_BIT] && !(wr_acc && idx == 10'(`CFTS_IDX_GCON))) begin
         next_gcon[`CFTS_GCON_CLR_BIT] = 1'b0;
      end
      if (rd_setup) begin
         unique case (idx)
            10'(`CFTS_IDX_GCON):    next_prdata[7:0] = gcon;
            10'(`CFTS_IDX_TIMH):    next_prdata[7:0] = count[15:8];
            10'(`CFTS_IDX_TIML):    next_prdata[7:0] = count[7:0];
            10'(`CFTS_IDX_TTCH):    next_prdata[7:0] = sync_cap[15:8];
            10'(`CFTS_IDX_TTCL):    next_prdata[7:0] = sync_cap[7:0];
            10'(`CFTS_IDX_STMPH):   next_prdata[7:0] = stamp_rd[15:8];
            10'(`CFTS_IDX_STMPL):   next_prdata[7:0] = stamp_rd[7:0];
            10'(`CFTS_IDX_OBJSEL):  next_prdata[OBJ_W-1:0] = obj_sel;
            10'(`CFTS_IDX_IRQSTAT): next_prdata[7:0] = irq_stat;
            10'(`CFTS_IDX_IRQMASK): next_prdata[7:0] = irq_mask;
            10'(`CFTS_IDX_PRESC):   next_prdata[7:0] = presc;
            default: ;
         endcase
      end
      // clear only the bits that the read returned, so an event after the setup edge survives
      if (rd_acc && idx == 10'(`CFTS_IDX_IRQSTAT)) begin
         next_irq_stat = irq_stat & ~prdata[7:0];
      end
      if (wrap) next_irq_stat[`CFTS_IRQ_WRAP_BIT] = 1'b1;
      if (sync_evt) next_irq_stat[`CFTS_IRQ_SYNC_BIT] = 1'b1;
      if (stamp_evt) next_irq_stat[`CFTS_IRQ_STAMP_BIT] = 1'b1;
      next_irq       = |(next_irq_stat & next_irq_mask);
      next_timer_irq = wrap && timer_overflow_irq_enable;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gcon      <= `CFTS_GCON_RESET;
         presc     <= `CFTS_PRESC_RESET;
         irq_mask  <= `CFTS_IRQ_RESET;
         irq_stat  <= `CFTS_IRQ_RESET;
         obj_sel   <= '0;
         prdata    <= 32'h0000_0000;
         irq       <= 1'b0;
         timer_irq <= 1'b0;
      end else begin
         gcon      <= next_gcon;
         presc     <= next_presc;
         irq_mask  <= next_irq_mask;
         irq_stat  <= next_irq_stat;
         obj_sel   <= next_obj_sel;
         prdata    <= next_prdata;
         irq       <= next_irq;
         timer_irq <= next_timer_irq;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // handshake and outputs to the protocol engine, all registered
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready                <= 1'b0;
         pslverr               <= 1'b0;
         controller_enable     <= 1'b0;
         single_shot           <= 1'b0;
         can_general_control_q <= `CFTS_GCON_RESET;
      end else begin
         pready                <= psel && !penable;
         pslverr               <= 1'b0;
         controller_enable     <= (next_run != CFTS_OFF);
         single_shot           <= next_gcon[`CFTS_GCON_TTM_BIT];
         can_general_control_q <= next_gcon;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // assertions
   wrap_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap && !gcon[`CFTS_GCON_CLR_BIT] |=> count == 16'h0000)
      else $error("count did not wrap to zero");
   stopped_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      run == CFTS_OFF && !gcon[`CFTS_GCON_CLR_BIT] |=> $stable(count))
      else $error("count moved while controller off");
   sync_take_a: assert property (@(posedge pclk) disable iff (!presetn)
      sync_evt |=> sync_cap == $past(count))
      else $error("sync capture missed");
   timer_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
      timer_irq |-> $past(wrap) && $past(timer_overflow_irq_enable))
      else $error("overflow irq without cause");
   timer_irq_set_a: assert property (@(posedge pclk) disable iff (!presetn)
      wrap && timer_overflow_irq_enable |=> timer_irq)
      else $error("overflow irq lost");
   no_sync_off_a: assert property (@(posedge pclk) disable iff (!presetn)
      !gcon[`CFTS_GCON_TTM_BIT] |=> $stable(sync_cap))
      else $error("sync capture outside tt mode");
   start_delay_a: assert property (@(posedge pclk) disable iff (!presetn)
      run == CFTS_OFF ##1 run == CFTS_STARTING |-> !running ##1 !running)
      else $error("counter started too early");
   tick_step_a: assert property (@(posedge pclk) disable iff (!presetn)
      tick && count != 16'hFFFF && !gcon[`CFTS_GCON_CLR_BIT] |=> count == $past(count) + 16'h0001)
      else $error("tick did not advance count");
   shot_a: assert property (@(posedge pclk) disable iff (!presetn)
      single_shot == gcon[`CFTS_GCON_TTM_BIT])
      else $error("single shot does not follow tt mode");
   cov_wrap_c:  cover property (@(posedge pclk) disable iff (!presetn) wrap);
   cov_sync_c:  cover property (@(posedge pclk) disable iff (!presetn) sync_evt);
   cov_stamp_c: cover property (@(posedge pclk) disable iff (!presetn) stamp_evt);
   cov_drain_c: cover property (@(posedge pclk) disable iff (!presetn) run == CFTS_DRAIN);
endmodule // cfts_timer

// ===== cfts_engine_model.sv
// protocol engine stand-in: frame edges, busy level and completion pulses
// assumes go is a one-cycle request taken at a rising edge of pclk
`timescale 1ns/1ps
module cfts_engine_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic       go,
   input  wire logic       go_tx,
   input  wire logic [3:0] go_obj,
   input  wire logic [7:0] go_len,
   output logic            frame_start,
   output logic            frame_end,
   output logic            frame_busy,
   output logic            rx_complete,
   output logic            tx_complete,
   output logic [3:0]      done_obj
);
   int         left;
   logic       tx_q;
   logic [3:0] obj_q;
   ////////////////////////////////////////////////////////////////////////////////
   // one frame at a time; completion lands with end of frame, still busy
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {frame_start, frame_end, frame_busy, rx_complete, tx_complete, tx_q} <= '0;
         {done_obj, obj_q} <= '0;
         left <= 0;
      end else begin
         {frame_start, frame_end, rx_complete, tx_complete} <= '0;
         done_obj <= ~done_obj;   // unqualified object number keeps moving
         if (go && left == 0 && !frame_busy) begin
            frame_start <= 1'b1;
            frame_busy <= 1'b1;
            left <= int'(go_len);
            tx_q <= go_tx;
            obj_q <= go_obj;
         end else if (left > 1) begin
            left <= left - 1;
         end else if (left == 1) begin
            left <= 0;
            frame_end <= 1'b1;
            rx_complete <= !tx_q;
            tx_complete <= tx_q;
            done_obj <= obj_q;
         end else begin
            frame_busy <= 1'b0;
         end
      end
   end
endmodule // cfts_engine_model

// ===== can_frame_timestamp_timer_bench.sv
// bench for the frame timestamp timer: apb master, engine model, cycle-log reference
// assumes the design files and cfts_engine_model.sv are compiled first
`timescale 1ns/1ps
`include "cfts_regs.svh"
module can_frame_timestamp_timer_bench;
   import cfts_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, go, go_tx, wrap_en;
   logic        pready, pslverr, fs, fe, fb, rxc, txc, timer_irq, irq, ctl_en, single_shot;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rv;
   logic [3:0]  go_obj, dobj;
   logic [7:0]  go_len, gcon_m, gq;
   logic [15:0] v, w;
   logic [31:0] rnd = 32'hF690C267;
   int          mismatches, compares, cyc, sync_cyc, pulses, anc_val, anc_cyc;
   int          stamp_cyc [16];
   cfts_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .frame_start(fs), .frame_end(fe), .frame_busy(fb), .rx_complete(rxc), .tx_complete(txc),
      .done_obj(dobj), .timer_overflow_irq_enable(wrap_en), .timer_irq(timer_irq), .irq(irq),
      .controller_enable(ctl_en), .single_shot(single_shot), .can_general_control_q(gq));
   cfts_engine_model eng (.pclk(pclk), .presetn(presetn), .go(go), .go_tx(go_tx), .go_obj(go_obj),
      .go_len(go_len), .frame_start(fs), .frame_end(fe), .frame_busy(fb), .rx_complete(rxc),
      .tx_complete(txc), .done_obj(dobj));
   ////////////////////////////////////////////////////////////////////////////////
   // 200 MHz clock
   initial begin
      pclk = 1'b0;
      forever #2.5 pclk = ~pclk;
   end
   // reference log: cycle of each capture cause and a count of wrap pulses
   always @(posedge pclk) begin
      if (gcon_m[5] && (gcon_m[4] ? fe : fs)) sync_cyc = cyc;
      if (rxc || txc) stamp_cyc[dobj] = cyc;
      if (timer_irq === 1'b1) pulses++;
      cyc++;
   end
   function automatic int nxt(int lo, int span);
      rnd ^= rnd << 13;
      rnd ^= rnd >> 17;
      rnd ^= rnd << 5;
      return lo + int'(rnd % span);
   endfunction
   // count expected at a logged cycle, one tick per clock with prescaler zero
   function automatic logic [31:0] cnt_at(int c);
      return 32'((anc_val + c - anc_cyc) & 32'h0000FFFF);
   endfunction
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic summarize;
      $display("comparisons %0d, mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic timeout;
      mismatches++;
      $display("mismatch at %0t: wait ran out", $time);
      summarize();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // one apb transfer; byte address is four times the register index
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [31:0] wd);
      int n;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'b00, idx, 2'b00};
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      n = 0;
      // pready is looked at on the rising edge itself, before that edge updates it
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (pready !== 1'b1) timeout();
      rv = prdata;
      check(pslverr, 32'h0);
      if (wr && idx == `CFTS_IDX_GCON) gcon_m <= wd[7:0];
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // sixteen-bit read, high byte then low byte
   task automatic rd16(input logic [7:0] hi, output logic [15:0] r);
      apb(1'b0, hi, 32'h0);
      r[15:8] = rv[7:0];
      apb(1'b0, hi + 8'h01, 32'h0);
      r[7:0] = rv[7:0];
   endtask
   task automatic launch(input logic tx, input int len);
      @(posedge pclk);
      go <= 1'b1;
      go_tx <= tx;
      go_obj <= 4'(nxt(0, 15));
      go_len <= 8'(len);
      @(posedge pclk);
      go <= 1'b0;
   endtask
   task automatic settle;
      int n;
      n = 0;
      do begin
         @(negedge pclk);
         n++;
      end while (fb !== 1'b0 && n < 300);
      if (fb !== 1'b0) timeout();
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {psel, penable, pwrite, go, go_tx, wrap_en} = '0;
      {paddr, pwdata, go_obj, go_len, gcon_m} = '0;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `CFTS_IDX_GCON, 32'h0);
      check(rv, 32'h0);
      apb(1'b1, 8'hC0, 32'hFF);
      apb(1'b0, 8'hC0, 32'h0);
      check(rv, 32'h0);
      apb(1'b1, `CFTS_IDX_GCON, 32'h3C);
      apb(1'b0, `CFTS_IDX_GCON, 32'h0);
      check(rv, 32'h3C);
      check({gq, single_shot, ctl_en}, {8'h3C, 2'b10});
      $display("test registers done");
      // stopped time base: a stamp taken before enable holds zero
      apb(1'b1, `CFTS_IDX_GCON, 32'h20);
      launch(1'b0, 6);
      settle();
      apb(1'b1, `CFTS_IDX_OBJSEL, 32'(go_obj));
      rd16(`CFTS_IDX_STMPH, v);
      check(v, 32'h0);
      $display("test stopped done");
      // running: sync capture on both edges, stamps on rx and tx
      apb(1'b1, `CFTS_IDX_PRESC, 32'h0);
      apb(1'b1, `CFTS_IDX_GCON, 32'h22);
      repeat (3) @(negedge pclk);
      check(ctl_en, 32'h1);
      for (int i = 0; i < 6; i++) begin
         apb(1'b1, `CFTS_IDX_GCON, i[0] ? 32'h32 : 32'h22);
         launch(i[0], nxt(3, 20));
         settle();
         rd16(`CFTS_IDX_TTCH, v);
         if (i == 0) begin
            anc_val = int'(v);
            anc_cyc = sync_cyc;
         end
         check(v, cnt_at(sync_cyc));
         apb(1'b1, `CFTS_IDX_OBJSEL, 32'(go_obj));
         rd16(`CFTS_IDX_STMPH, v);
         check(v, cnt_at(stamp_cyc[go_obj]));
      end
      $display("test captures done");
      // wrap: one pulse, status held while masked, irq follows the mask
      apb(1'b1, `CFTS_IDX_IRQMASK, 32'h0);
      apb(1'b0, `CFTS_IDX_IRQSTAT, 32'h0);
      wrap_en <= 1'b1;
      pulses = 0;
      repeat (65544 - cnt_at(cyc)) @(posedge pclk);
      check(pulses, 32'h1);
      check(irq, 32'h0);
      apb(1'b1, `CFTS_IDX_IRQMASK, 32'h1);
      repeat (2) @(negedge pclk);
      check(irq, 32'h1);
      apb(1'b0, `CFTS_IDX_IRQSTAT, 32'h0);
      check(rv, 32'h1);
      repeat (2) @(negedge pclk);
      check(irq, 32'h0);
      launch(1'b0, 5);
      settle();
      rd16(`CFTS_IDX_TTCH, v);
      check(v, cnt_at(sync_cyc));
      $display("test wrap done");
      // drain: enable cleared mid-frame, count runs to frame end then stops
      launch(1'b1, 40);
      apb(1'b1, `CFTS_IDX_GCON, 32'h30);
      repeat (2) @(negedge pclk);
      check(ctl_en, 32'h1);
      settle();
      repeat (3) @(negedge pclk);
      check(ctl_en, 32'h0);
      rd16(`CFTS_IDX_TTCH, v);
      check(v, cnt_at(sync_cyc));
      launch(1'b0, 4);
      settle();
      rd16(`CFTS_IDX_TIMH, w);
      launch(1'b0, 9);
      settle();
      rd16(`CFTS_IDX_TIMH, v);
      check(v, w);
      // general reset clears the stopped count and clears itself
      apb(1'b1, `CFTS_IDX_GCON, 32'h01);
      rd16(`CFTS_IDX_TIMH, v);
      check(v, 32'h0);
      apb(1'b0, `CFTS_IDX_GCON, 32'h0);
      check(rv, 32'h0);
      $display("test drain done");
      summarize();
   end
endmodule // can_frame_timestamp_timer_bench
